// file: ezb_i2c_master.sv
`timescale 1ns/1ps
`default_nettype none
module ezb_i2c_master (
  input wire logic clock,
  input wire logic sda_in,
  output logic scl,
  output logic sda
);
  // Released SDA is 1; the wire and pull-up resolve it
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clock);
  endtask : hold
  // Also serves as repeated start from clock low
  task automatic start();
    sda <= 1'b1;
    hold(2);
    scl <= 1'b1;
    hold(4);
    sda <= 1'b0;
    hold(4);
    scl <= 1'b0;
    hold(2);
  endtask : start
  task automatic stop();
    sda <= 1'b0;
    hold(2);
    scl <= 1'b1;
    hold(4);
    sda <= 1'b1;
    hold(4);
  endtask : stop
  // Nine bits MSB first, 400 ns each
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda <= tx[i];
      hold(2);
      scl <= 1'b1;
      hold(2);
      rx[i] = sda_in;
      hold(2);
      scl <= 1'b0;
      hold(2);
    end
  endtask : xfer
endmodule : ezb_i2c_master
`default_nettype wire

// file: ezb_pkg.sv
package ezb_pkg;
  localparam int unsigned EZB_ADDR_W = 8;
  localparam int unsigned EZB_PTR_W = 5;
  localparam int unsigned EZB_DEPTH = 32;
  // Register indices; byte address is four times the index
  localparam logic [7:0] EZB_IDX_BUS_CP = 8'hCC;
  localparam logic [7:0] EZB_IDX_CPU_SIDE_BASE_POINTER = 8'hCD;
  localparam logic [7:0] EZB_IDX_CPU_SIDE_CURRENT_POINTER = 8'hCE;
  localparam logic [7:0] EZB_IDX_BUF = 8'hCF;
  localparam logic [7:0] EZB_IDX_CFG = 8'hD6;
  localparam logic [7:0] EZB_IDX_MODE = 8'hD8;
  localparam logic [7:0] EZB_IDX_STAT = 8'hD9;
  // Configuration fields
  localparam int unsigned EZB_CFG_EN_BIT = 0;
  localparam int unsigned EZB_CFG_RATE_LO = 2;
  localparam int unsigned EZB_CFG_STOPIE_BIT = 4;
  localparam int unsigned EZB_CFG_PSEL_BIT = 6;
  localparam logic [7:0] EZB_CFG_WMASK = 8'h5D;
  localparam logic [7:0] EZB_CFG_RESET = 8'h00;
  localparam logic [7:0] EZB_PTR_RESET = 8'h00;
  localparam logic [1:0] EZB_RATE_100K = 2'h0;
  localparam logic [1:0] EZB_RATE_400K = 2'h1;
  localparam logic [1:0] EZB_RATE_50K = 2'h2;
  localparam logic [7:0] EZB_I2C_ADDR_RESET = 8'h08;
  typedef enum logic [2:0] {
    EZB_IDLE, EZB_ADDR, EZB_ADDR_ACK, EZB_WDATA, EZB_WACK, EZB_RDATA, EZB_RACK
  } ezb_state_e;
endpackage : ezb_pkg

// file: ezb_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ezb_properties
  import ezb_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic instruction_execute_phase,
  input wire logic scl_a_in,
  input wire logic scl_b_in,
  input wire logic sda_a_oe_n,
  input wire logic sda_b_oe_n,
  input wire logic stop_irq,
  input wire logic [1:0] rate_sel
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic [1:0] wd_rate;
  assign wd_rate = pwdata[3:2];
  ////////////////////////////////////////////////////////////
  sequence s_rd(logic [7:0] idx);
    psel && penable && pready && !pwrite && paddr == {22'h0, idx, 2'h0};
  endsequence
  sequence s_wr(logic [7:0] idx);
    psel && penable && pready && pwrite && paddr == {22'h0, idx, 2'h0};
  endsequence
  ////////////////////////////////////////////////////////////
  AST_ONE_WAIT: assert property (psel && penable && !pready |=> pready && !pslverr)
    else $error("apb access stalled or erred");
  AST_RATE: assert property (s_wr(EZB_IDX_CFG) |=> rate_sel == $past(wd_rate))
    else $error("rate select not taken from write");
  AST_RST: assert property ($fell(sys_rst) |-> rate_sel == 2'h0 && sda_a_oe_n && sda_b_oe_n)
    else $error("outputs not at reset level");
  AST_IRQ_PULSE: assert property (stop_irq |=> !stop_irq)
    else $error("stop interrupt longer than one cycle");
  AST_IRQ_SCL: assert property (stop_irq |-> scl_a_in && scl_b_in)
    else $error("stop interrupt without clock high");
  AST_ONE_PAIR: assert property (!(!sda_a_oe_n && !sda_b_oe_n))
    else $error("both pin pairs driven");
  AST_SDA_LOW: assert property ($changed(sda_a_oe_n) |-> !scl_a_in)
    else $error("data changed while clock high");
  AST_NOEXEC: assert property (s_rd(EZB_IDX_BUF) ##0 !instruction_execute_phase |=> prdata == 0)
    else $error("first phase read returned data");
  AST_CP_W: assert property (s_rd(EZB_IDX_CPU_SIDE_CURRENT_POINTER) |=> prdata[31:5] == 27'h0)
    else $error("cpu pointer wider than five bits");
endmodule : ezb_properties
`default_nettype wire

// file: ezb_ram_slave.sv
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Loading the bus base pointer also loads the bus current pointer.
// - Bus current pointer increments after every completed data byte except the first written one, which loads it.
// - Bus current pointer wraps to zero after the 32nd byte.
// - Every bus buffer access uses the bus current pointer.
// - Each start or repeated start reloads the bus current pointer from base.
// - Only CPU writes and disabling change CPU base; each write also sets CPU current.
// - CPU current pointer increments after each counted window access.
// - Window read returns byte at CPU current; window write stores there unless the bus writes that byte in the same cycle.
// - Unwritten buffer locations may read any value.
// - Window reads outside the execute phase are ignored.
// - In compatibility mode pointers and data window do nothing.
// - Config bit 6 selects default or alternate pin pair for clock and data.
// - Pin select is frozen by writes that keep enable set while enabled; any other config write, including the enabling one, loads it.
// - Config bit 4 enables an interrupt on stop detection.
// - Configuration bits 0, 2, 3, 4 and 6 are read-write, the others read zero; all reset to zero.
// - First written data byte after the address loads the bus base pointer.
// - Disabled block holds pointers and bus engine in reset and blocks window access; config and mode stay writable.
// - Slave looks like 32-byte RAM, never stretches clock, auto-acknowledges.
module ezb_ram_slave (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instruction_execute_phase,
  input wire logic scl_a_in,
  input wire logic sda_a_in,
  output logic sda_a_oe_n,
  input wire logic scl_b_in,
  input wire logic sda_b_in,
  output logic sda_b_oe_n,
  output logic stop_irq,
  output logic [1:0] rate_sel
);
  import ezb_pkg::*;

  function automatic logic reg_hit(input logic [31:0] a, input logic [7:0] idx);
    reg_hit = (a[31:2] == {22'h000000, idx}) && (a[1:0] == 2'h0);
  endfunction : reg_hit

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and pin-pair select
  logic [3:0] pin_s1_reg, pin_s2_reg, pin_s1_next;
  logic scl_s, sda_s, scl_d_reg, sda_d_reg;
  logic [7:0] cfg_reg, cfg_next;
  logic enabled;
  assign enabled = cfg_reg[EZB_CFG_EN_BIT];
  assign pin_s1_next = {scl_a_in, sda_a_in, scl_b_in, sda_b_in};
  always_ff @(posedge clock) begin
    pin_s1_reg <= pin_s1_next;
    pin_s2_reg <= pin_s1_reg;
    scl_d_reg <= scl_s;
    sda_d_reg <= sda_s;
  end
  always_comb begin
    if (cfg_reg[EZB_CFG_PSEL_BIT]) begin
      scl_s = pin_s2_reg[1];
      sda_s = pin_s2_reg[0];
    end else begin
      scl_s = pin_s2_reg[3];
      sda_s = pin_s2_reg[2];
    end
  end
  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = scl_s && !scl_d_reg;
  assign scl_fall = !scl_s && scl_d_reg;
  assign start_det = enabled && scl_s && scl_d_reg && !sda_s && sda_d_reg;
  assign stop_det = enabled && scl_s && scl_d_reg && sda_s && !sda_d_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Registers and APB
  logic mode_reg, mode_next;
  logic [6:0] i2c_addr_reg, i2c_addr_next;
  logic [4:0] cpu_side_base_pointer_reg, cpu_side_base_pointer_next, cpu_side_current_pointer_reg, cpu_side_current_pointer_next;
  logic [31:0] prdata_reg, prdata_next;
  logic [7:0] ram [0:EZB_DEPTH-1];
  logic acc, wr_acc, rd_acc, buf_hit, win_ok, cpu_ram_we, bus_ram_we;
  logic [4:0] bus_cp_reg;
  logic [7:0] bus_wbyte;
  // One wait state: read data is loaded in the first access cycle
  // so that it already stands from a flip-flop when pready is high
  logic wait_reg, wait_next, rd_load;
  assign pready = wait_reg;
  assign pslverr = 1'b0;
  assign prdata = prdata_reg;
  // Writes and pointer side effects land only at the completing edge
  assign acc = psel && penable && wait_reg;
  assign rd_load = psel && penable && !pwrite && !wait_reg;
  assign wr_acc = acc && pwrite;
  assign rd_acc = acc && !pwrite;
  assign buf_hit = reg_hit(paddr, EZB_IDX_BUF);
  assign win_ok = enabled && mode_reg;
  assign cpu_ram_we = wr_acc && buf_hit && win_ok && !(bus_ram_we && bus_cp_reg == cpu_side_current_pointer_reg);
  assign stop_irq = stop_det && cfg_reg[EZB_CFG_STOPIE_BIT];
  assign rate_sel = cfg_reg[EZB_CFG_RATE_LO +: 2];

  always_comb begin
    cfg_next = cfg_reg;
    mode_next = mode_reg;
    i2c_addr_next = i2c_addr_reg;
    cpu_side_base_pointer_next = cpu_side_base_pointer_reg;
    cpu_side_current_pointer_next = cpu_side_current_pointer_reg;
    prdata_next = prdata_reg;
    wait_next = psel && penable && !wait_reg;
    if (wr_acc && reg_hit(paddr, EZB_IDX_CFG)) begin
      cfg_next = pwdata[7:0] & EZB_CFG_WMASK;
      if (enabled && pwdata[EZB_CFG_EN_BIT]) begin
        cfg_next[EZB_CFG_PSEL_BIT] = cfg_reg[EZB_CFG_PSEL_BIT];
      end
    end
    if (wr_acc && reg_hit(paddr, EZB_IDX_MODE)) begin
      mode_next = pwdata[0];
      i2c_addr_next = pwdata[14:8];
    end
    if (wr_acc && reg_hit(paddr, EZB_IDX_CPU_SIDE_BASE_POINTER) && win_ok) begin
      cpu_side_base_pointer_next = pwdata[4:0];
      cpu_side_current_pointer_next = pwdata[4:0];
    end
    if (win_ok && buf_hit && (wr_acc || (rd_acc && instruction_execute_phase))) begin
      cpu_side_current_pointer_next = cpu_side_current_pointer_reg + 5'h01;
    end
    if (!enabled) begin
      cpu_side_base_pointer_next = 5'h00;
      cpu_side_current_pointer_next = 5'h00;
    end
    if (rd_load) begin
      prdata_next = 32'h00000000;
      if (reg_hit(paddr, EZB_IDX_BUS_CP)) prdata_next[4:0] = bus_cp_reg;
      if (reg_hit(paddr, EZB_IDX_CPU_SIDE_BASE_POINTER)) prdata_next[4:0] = cpu_side_base_pointer_reg;
      if (reg_hit(paddr, EZB_IDX_CPU_SIDE_CURRENT_POINTER)) prdata_next[4:0] = cpu_side_current_pointer_reg;
      if (reg_hit(paddr, EZB_IDX_CFG)) prdata_next[7:0] = cfg_reg;
      if (reg_hit(paddr, EZB_IDX_MODE)) prdata_next[14:0] = {i2c_addr_reg, 7'h00, mode_reg};
      if (buf_hit && win_ok && instruction_execute_phase) begin
        prdata_next[7:0] = ram[cpu_side_current_pointer_reg];
      end
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cfg_reg <= EZB_CFG_RESET;
      mode_reg <= 1'b0;
      i2c_addr_reg <= EZB_I2C_ADDR_RESET[6:0];
      cpu_side_base_pointer_reg <= EZB_PTR_RESET[4:0];
      cpu_side_current_pointer_reg <= EZB_PTR_RESET[4:0];
      prdata_reg <= 32'h00000000;
      wait_reg <= 1'b0;
    end else begin
      wait_reg <= wait_next;
      cfg_reg <= cfg_next;
      mode_reg <= mode_next;
      i2c_addr_reg <= i2c_addr_next;
      cpu_side_base_pointer_reg <= cpu_side_base_pointer_next;
      cpu_side_current_pointer_reg <= cpu_side_current_pointer_next;
      prdata_reg <= prdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // I2C slave engine; data is driven after SCL falls, never stretched
  ezb_state_e st_reg, st_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] sh_reg, sh_next;
  logic [4:0] bus_bp_reg, bus_bp_next, bus_cp_next;
  logic first_reg, first_next, oe_n_reg, oe_n_next;
  logic [7:0] rd_byte;
  assign rd_byte = ram[bus_cp_reg];
  assign bus_wbyte = sh_reg;
  assign sda_a_oe_n = cfg_reg[EZB_CFG_PSEL_BIT] ? 1'b1 : oe_n_reg;
  assign sda_b_oe_n = cfg_reg[EZB_CFG_PSEL_BIT] ? oe_n_reg : 1'b1;

  always_comb begin
    st_next = st_reg;
    bit_next = bit_reg;
    sh_next = sh_reg;
    bus_bp_next = bus_bp_reg;
    bus_cp_next = bus_cp_reg;
    first_next = first_reg;
    oe_n_next = oe_n_reg;
    bus_ram_we = 1'b0;
    case (st_reg)
      EZB_IDLE: ;
      EZB_ADDR: begin
        if (scl_rise) begin
          sh_next = {sh_reg[6:0], sda_s};
          bit_next = bit_reg + 4'h1;
        end
        if (scl_fall && bit_reg == 4'h8) begin
          if (sh_reg[7:1] == i2c_addr_reg && mode_reg) begin
            oe_n_next = 1'b0;
            st_next = EZB_ADDR_ACK;
          end else begin
            st_next = EZB_IDLE;
          end
        end
      end
      EZB_ADDR_ACK: begin
        if (scl_fall) begin
          bit_next = 4'h0;
          if (sh_reg[0]) begin
            sh_next = rd_byte;
            oe_n_next = rd_byte[7];
            st_next = EZB_RDATA;
          end else begin
            oe_n_next = 1'b1;
            first_next = 1'b1;
            st_next = EZB_WDATA;
          end
        end
      end
      EZB_WDATA: begin
        if (scl_rise) begin
          sh_next = {sh_reg[6:0], sda_s};
          bit_next = bit_reg + 4'h1;
        end
        if (scl_fall && bit_reg == 4'h8) begin
          oe_n_next = 1'b0;
          st_next = EZB_WACK;
          if (first_reg) begin
            bus_bp_next = sh_reg[4:0];
            bus_cp_next = sh_reg[4:0];
            first_next = 1'b0;
          end else begin
            bus_ram_we = 1'b1;
            bus_cp_next = bus_cp_reg + 5'h01;
          end
        end
      end
      EZB_WACK: begin
        if (scl_fall) begin
          oe_n_next = 1'b1;
          bit_next = 4'h0;
          st_next = EZB_WDATA;
        end
      end
      EZB_RDATA: begin
        if (scl_fall) begin
          bit_next = bit_reg + 4'h1;
          sh_next = {sh_reg[6:0], 1'b1};
          oe_n_next = (bit_reg == 4'h7) ? 1'b1 : sh_reg[6];
          if (bit_reg == 4'h7) begin
            bus_cp_next = bus_cp_reg + 5'h01;
            first_next = 1'b0;
            st_next = EZB_RACK;
          end
        end
      end
      // Ack seen on the rise; next byte's first bit goes out on the fall
      EZB_RACK: begin
        if (scl_rise) begin
          if (sda_s) begin
            st_next = EZB_IDLE;
          end else begin
            first_next = 1'b1;
          end
        end
        if (scl_fall && first_reg) begin
          first_next = 1'b0;
          bit_next = 4'h0;
          sh_next = rd_byte;
          oe_n_next = rd_byte[7];
          st_next = EZB_RDATA;
        end
      end
      default: st_next = EZB_IDLE;
    endcase
    if (stop_det) begin
      st_next = EZB_IDLE;
      oe_n_next = 1'b1;
    end
    if (start_det) begin
      st_next = EZB_ADDR;
      bit_next = 4'h0;
      oe_n_next = 1'b1;
      bus_cp_next = bus_bp_reg;
    end
    if (!enabled || !mode_reg) begin
      st_next = EZB_IDLE;
      oe_n_next = 1'b1;
      bus_bp_next = 5'h00;
      bus_cp_next = 5'h00;
      bus_ram_we = 1'b0;
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_reg <= EZB_IDLE;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      bus_bp_reg <= EZB_PTR_RESET[4:0];
      bus_cp_reg <= EZB_PTR_RESET[4:0];
      first_reg <= 1'b0;
      oe_n_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      bus_bp_reg <= bus_bp_next;
      bus_cp_reg <= bus_cp_next;
      first_reg <= first_next;
      oe_n_reg <= oe_n_next;
    end
  end

  // Buffer has no reset: contents undefined until written
  always_ff @(posedge clock) begin
    if (bus_ram_we) begin
      ram[bus_cp_reg] <= bus_wbyte;
    end
    if (cpu_ram_we) begin
      ram[cpu_side_current_pointer_reg] <= pwdata[7:0];
    end
  end
endmodule : ezb_ram_slave
`default_nettype wire

// file: test_ezb_ram_slave.sv
`timescale 1ns/1ps
`default_nettype none
bind ezb_ram_slave ezb_properties i_ezb_properties (.clock(clock), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_a_in(scl_a_in),
  .instruction_execute_phase(instruction_execute_phase), .scl_b_in(scl_b_in),
  .sda_a_oe_n(sda_a_oe_n), .sda_b_oe_n(sda_b_oe_n), .stop_irq(stop_irq), .rate_sel(rate_sel));
module test_ezb_ram_slave;
  import ezb_pkg::*;
  logic clock = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic exe = 1'b1, use_b = 1'b0, pready, pslverr, a_oe_n, b_oe_n, stop_irq;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rv;
  logic [1:0] rate_sel;
  logic [7:0] mem [32];
  logic [8:0] rx;
  wire logic m_scl, m_sda, sda_w;
  int n_fail = 0, n_tests = 0, n_irq = 0;
  always #25 clock = ~clock;
  assign sda_w = m_sda & (use_b ? b_oe_n : a_oe_n);
  always @(posedge clock) if (stop_irq === 1'b1) n_irq <= n_irq + 1;
  ezb_i2c_master i_ezb_i2c_master (.clock(clock), .sda_in(sda_w), .scl(m_scl), .sda(m_sda));
  ezb_ram_slave i_ezb_ram_slave (.clock(clock), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .instruction_execute_phase(exe),
    .scl_a_in(use_b | m_scl), .sda_a_in(use_b | sda_w), .sda_a_oe_n(a_oe_n),
    .scl_b_in(~use_b | m_scl), .sda_b_in(~use_b | sda_w), .sda_b_oe_n(b_oe_n),
    .stop_irq(stop_irq), .rate_sel(rate_sel));
  ////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Read data taken at the edge where pready is high
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int i;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h0, idx, 2'h0};
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1) begin
      n_fail++;
      tally_and_finish();
    end
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rv, exp);
  endtask : rd
  task automatic cpu_rd(input logic [4:0] p, input int n);
    apb(1'b1, EZB_IDX_CPU_SIDE_BASE_POINTER, {27'h0, p});
    for (int i = 0; i < n; i++) rd(EZB_IDX_BUF, {24'h0, mem[p + 5'(i)]});
  endtask : cpu_rd
  task automatic i2c_hdr(input logic [4:0] p);
    i_ezb_i2c_master.start();
    i_ezb_i2c_master.xfer({EZB_I2C_ADDR_RESET << 1, 1'b1}, rx);
    i_ezb_i2c_master.xfer({3'h0, p, 1'b1}, rx);
    chk({31'h0, rx[0]}, 32'h0);
  endtask : i2c_hdr
  task automatic i2c_wr(input logic [4:0] p, input int n);
    i2c_hdr(p);
    repeat (n) begin
      mem[p] = 8'($urandom);
      i_ezb_i2c_master.xfer({mem[p], 1'b1}, rx);
      chk({31'h0, rx[0]}, 32'h0);
      p++;
    end
    i_ezb_i2c_master.stop();
  endtask : i2c_wr
  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h707008DE));
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    rd(EZB_IDX_CFG, 32'h0);
    rd(EZB_IDX_BUS_CP, 32'h0);
    rd(EZB_IDX_CPU_SIDE_BASE_POINTER, 32'h0);
    rd(8'h00, 32'h0);
    for (int r = 0; r < 3; r++) begin
      apb(1'b1, EZB_IDX_CFG, 32'(r << 2));
      rd(EZB_IDX_CFG, 32'(r << 2));
      chk({30'h0, rate_sel}, 32'(r));
    end
    apb(1'b1, EZB_IDX_CFG, 32'h01);
    apb(1'b1, EZB_IDX_CPU_SIDE_BASE_POINTER, 32'h07);
    rd(EZB_IDX_CPU_SIDE_CURRENT_POINTER, 32'h0);
    apb(1'b1, EZB_IDX_MODE, 32'h801);
    apb(1'b1, EZB_IDX_CFG, 32'h11);
    apb(1'b1, EZB_IDX_CPU_SIDE_BASE_POINTER, 32'h1E);
    rd(EZB_IDX_CPU_SIDE_CURRENT_POINTER, 32'h1E);
    for (logic [4:0] p = 5'h1E; p != 5'h01; p++) begin
      mem[p] = 8'($urandom);
      apb(1'b1, EZB_IDX_BUF, {24'h0, mem[p]});
    end
    rd(EZB_IDX_CPU_SIDE_CURRENT_POINTER, 32'h01);
    apb(1'b1, EZB_IDX_CPU_SIDE_BASE_POINTER, 32'h1E);
    exe <= 1'b0;
    rd(EZB_IDX_BUF, 32'h0);
    rd(EZB_IDX_CPU_SIDE_CURRENT_POINTER, 32'h1E);
    exe <= 1'b1;
    cpu_rd(5'h1E, 3);
    i2c_wr(5'h1D, 4);
    chk(32'(n_irq), 32'h1);
    rd(EZB_IDX_BUS_CP, 32'h01);
    cpu_rd(5'h1D, 4);
    i2c_hdr(5'h1E);
    i_ezb_i2c_master.start();
    i_ezb_i2c_master.xfer({(EZB_I2C_ADDR_RESET << 1) | 8'h01, 1'b1}, rx);
    i_ezb_i2c_master.xfer(9'h1FE, rx);
    chk({24'h0, rx[8:1]}, {24'h0, mem[30]});
    i_ezb_i2c_master.xfer(9'h1FF, rx);
    chk({24'h0, rx[8:1]}, {24'h0, mem[31]});
    i_ezb_i2c_master.stop();
    apb(1'b1, EZB_IDX_CFG, 32'h00);
    rd(EZB_IDX_CPU_SIDE_CURRENT_POINTER, 32'h0);
    apb(1'b1, EZB_IDX_CFG, 32'h41);
    rd(EZB_IDX_CFG, 32'h41);
    use_b <= 1'b1;
    i2c_wr(5'h05, 1);
    cpu_rd(5'h05, 1);
    chk(32'(n_irq), 32'h2);
    apb(1'b1, EZB_IDX_CFG, 32'h01);
    rd(EZB_IDX_CFG, 32'h41);
    tally_and_finish();
  end
  initial begin
    #1ms;
    n_fail++;
    tally_and_finish();
  end
endmodule : test_ezb_ram_slave
`default_nettype wire
